/* hw/i2c_gpio_expander_8bit.sv */
// i2c slave 8-bit gpio expander core with change alert
`timescale 1ns/10ps
`include "gpio_exp_params.svh"

// Contract
// - answer only address 0111 plus the three strap pins, 0x38 to 0x3f.
// - address byte lsb 1 means read, 0 means write.
// - acknowledge a matching address by holding sda low in ninth clock.
// - sda falling while scl high is start; restart the bus machine.
// - sda rising while scl high is stop; return to idle.
// - bytes are eight bits msb first plus an acknowledge bit.
// - sda changes only while scl low; high-phase changes are start/stop.
// - acknowledge every byte received while addressed for write.
// - master nacks the last read byte; device then releases sda.
// - transmitter releases sda before the acknowledge bit.
// - alert low while any input line differs from input register.
// - any input edge raises alert within the alert valid delay.
// - alert clears on return of inputs or at input read ack rise.
// - input change during read ack pulse may be lost or short.
// - after clearing, every further input change alerts again.
// - output-configured lines never raise the alert.
// - traffic to other slaves neither sets nor clears the alert.
// - switching output to input alerts if pin differs from register.
// - input lines have both drivers off and a weak pull-up.
// - output lines enable high or low driver from output register bit.
// - reset loads defaults, all lines inputs, bus machine idle.
// - input register value inverted where polarity bit is set.
// - first write byte is pointer: 0 input, 1 output, 2 polarity, 3 dir.
// - direction bit 1 makes input, 0 makes output.
// - pointer never increments; last written byte stays.
// - pointer holds for later reads; every read byte is same register.
module i2c_gpio_expander_8bit
	import gpio_exp_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_addr_strap_bit0,
	input wire logic i_addr_strap_bit1,
	input wire logic i_addr_strap_bit2,
	input wire logic [WIDTH-1:0] i_io_lines,
	output logic [WIDTH-1:0] o_io_lines,
	output logic [WIDTH-1:0] o_io_lines_oe,
	output logic [WIDTH-1:0] o_high_side_driver,
	output logic [WIDTH-1:0] o_low_side_driver,
	output logic [WIDTH-1:0] o_pullup_en,
	output logic o_alert_n_out,
	output logic o_alert_n_oe
);

	i2c_evt_if evt ();

	i2c_line_monitor u_line_monitor (
		.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.evt(evt)
	);

	// pin synchronisers
	logic [WIDTH-1:0] io_sync1_q;
	logic [WIDTH-1:0] io_sync2_q;
	logic [2:0] strap_sync1_q;
	logic [2:0] strap_sync2_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			io_sync1_q <= '1;
			io_sync2_q <= '1;
			strap_sync1_q <= 3'h0;
			strap_sync2_q <= 3'h0;
		end else begin
			io_sync1_q <= i_io_lines;
			io_sync2_q <= io_sync1_q;
			strap_sync1_q <= {i_addr_strap_bit2, i_addr_strap_bit1,
				i_addr_strap_bit0};
			strap_sync2_q <= strap_sync1_q;
		end
	end

	// bus state and registers
	bus_state_t state_q;
	bus_state_t state_d;
	logic [3:0] bit_cnt_q;
	logic [3:0] bit_cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic sda_oe_q;
	logic sda_oe_d;
	logic nack_q;
	logic nack_d;
	reg_ptr_t ptr_q;
	reg_ptr_t ptr_d;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;
	logic [WIDTH-1:0] pol_q;
	logic [WIDTH-1:0] pol_d;
	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] dir_d;
	logic [WIDTH-1:0] in_ref_q;
	logic [WIDTH-1:0] in_ref_d;
	logic [1:0] prime_q;
	logic [1:0] prime_d;
	logic alert_q;
	logic alert_d;
	logic [7:0] rdata;
	logic addr_match;
	logic byte_done;

	assign addr_match = (shift_q[7:1] == {`ADDR_FIXED_HI, strap_sync2_q});
	assign byte_done = (bit_cnt_q == `BITS_PER_BYTE);

	always_comb begin
		rdata = 8'h00;
		unique case (ptr_q)
			`PTR_INPUT: begin
				rdata[WIDTH-1:0] = io_sync2_q ^ pol_q;
			end
			`PTR_OUTPUT: begin
				rdata[WIDTH-1:0] = out_q;
			end
			`PTR_POLARITY: begin
				rdata[WIDTH-1:0] = pol_q;
			end
			`PTR_DIRECTION: begin
				rdata[WIDTH-1:0] = dir_q;
			end
		endcase
	end

	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		sda_oe_d = sda_oe_q;
		nack_d = nack_q;
		ptr_d = ptr_q;
		out_d = out_q;
		pol_d = pol_q;
		dir_d = dir_q;
		in_ref_d = in_ref_q;
		prime_d = prime_q;
		// initial reference once synchronisers hold real pin levels
		if (prime_q != 2'h3) begin
			prime_d = prime_q + 2'h1;
			if (prime_q == 2'h2) begin
				in_ref_d = io_sync2_q;
			end
		end
		if (evt.start) begin
			// restart on start or repeated start
			state_d = ST_ADDR;
			bit_cnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else if (evt.stop) begin
			state_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_IGNORE: begin
					sda_oe_d = 1'b0;
				end
				ST_ADDR, ST_CMD, ST_WDATA: begin
					// sample data on scl rise only
					if (evt.scl_rise && !byte_done) begin
						shift_d = {shift_q[6:0], evt.sda};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					if (evt.scl_fall && byte_done) begin
						bit_cnt_d = 4'h0;
						sda_oe_d = 1'b1;
						if (state_q == ST_ADDR) begin
							if (addr_match) begin
								state_d = ST_ADDR_ACK;
							end else begin
								state_d = ST_IGNORE;
								sda_oe_d = 1'b0;
							end
						end else if (state_q == ST_CMD) begin
							// pointer stored from its low two bits, no increment
							ptr_d = shift_q[1:0];
							state_d = ST_CMD_ACK;
						end else begin
							// acknowledge data byte and store it, except with the input pointer
							state_d = ST_WDATA_ACK;
							unique case (ptr_q)
								`PTR_INPUT: begin
								end
								`PTR_OUTPUT: begin
									out_d = shift_q[WIDTH-1:0];
								end
								`PTR_POLARITY: begin
									pol_d = shift_q[WIDTH-1:0];
								end
								`PTR_DIRECTION: begin
									dir_d = shift_q[WIDTH-1:0];
								end
							endcase
						end
					end
				end
				ST_ADDR_ACK: begin
					if (evt.scl_fall) begin
						if (shift_q[0]) begin
							state_d = ST_RDATA;
							shift_d = rdata;
							sda_oe_d = ~rdata[7];
						end else begin
							state_d = ST_CMD;
							sda_oe_d = 1'b0;
						end
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					if (evt.scl_fall) begin
						state_d = ST_WDATA;
						sda_oe_d = 1'b0;
					end
				end
				ST_RDATA: begin
					if (evt.scl_rise) begin
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					if (evt.scl_fall) begin
						if (byte_done) begin
							state_d = ST_RDATA_ACK;
							bit_cnt_d = 4'h0;
							sda_oe_d = 1'b0;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							sda_oe_d = ~shift_q[6];
						end
					end
				end
				ST_RDATA_ACK: begin
					if (evt.scl_rise) begin
						nack_d = evt.sda;
						if (ptr_q == `PTR_INPUT) begin
							// read clears alert at ack rise
							// change before this rise is absorbed, a later one alerts
							in_ref_d = io_sync2_q;
						end
					end
					if (evt.scl_fall) begin
						// nack_q was taken at the rise of this pulse
						if (nack_q) begin
							state_d = ST_IGNORE;
							sda_oe_d = 1'b0;
						end else begin
							state_d = ST_RDATA;
							shift_d = rdata;
							sda_oe_d = ~rdata[7];
						end
					end
				end
				// upset state codes fall back to idle, bus released
				default: begin
					state_d = ST_IDLE;
					sda_oe_d = 1'b0;
				end
			endcase
		end
		// pure compare, so a set and a clear never meet in one cycle
		// compare inputs against reference
		alert_d = |((io_sync2_q ^ in_ref_q) & dir_q);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			sda_oe_q <= 1'b0;
			nack_q <= 1'b0;
			ptr_q <= `PTR_RESET;
			out_q <= `OUTPUT_RESET;
			pol_q <= `POLARITY_RESET;
			dir_q <= `DIRECTION_RESET;
			in_ref_q <= `INPUT_REF_RESET;
			prime_q <= 2'h0;
			alert_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			sda_oe_q <= sda_oe_d;
			nack_q <= nack_d;
			ptr_q <= ptr_d;
			out_q <= out_d;
			pol_q <= pol_d;
			dir_q <= dir_d;
			in_ref_q <= in_ref_d;
			prime_q <= prime_d;
			alert_q <= alert_d;
		end
	end

	// open-drain sda: only ever pulls low
	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_q;

	// alert lags an input edge by three clocks
	assign o_alert_n_out = 1'b0;
	assign o_alert_n_oe = alert_q;

	// direction 0 drives, 1 is input
	assign o_io_lines = out_q;
	assign o_io_lines_oe = ~dir_q;
	assign o_high_side_driver = ~dir_q & out_q;
	assign o_low_side_driver = ~dir_q & ~out_q;
	assign o_pullup_en = dir_q;

endmodule

/* hw/gpio_exp_params.svh */
// constants for the i2c gpio expander: address, pointers, defaults, timing
`ifndef GPIO_EXP_PARAMS_SVH
`define GPIO_EXP_PARAMS_SVH

`define ADDR_FIXED_HI 4'h7
`define PTR_INPUT 2'h0
`define PTR_OUTPUT 2'h1
`define PTR_POLARITY 2'h2
`define PTR_DIRECTION 2'h3
`define PTR_RESET 2'h0
`define OUTPUT_RESET 8'hff
`define POLARITY_RESET 8'h00
`define DIRECTION_RESET 8'hff
`define INPUT_REF_RESET 8'hff
`define BITS_PER_BYTE 4'h8
`define CLK_PERIOD_NS 10
`define ALERT_VALID_DELAY_NS 4000
`define ALERT_VALID_CYCLES (`ALERT_VALID_DELAY_NS / `CLK_PERIOD_NS)

`endif

/* hw/gpio_exp_pkg.sv */
// types shared by the i2c gpio expander modules
package gpio_exp_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK,
		ST_IGNORE
	} bus_state_t;

	typedef logic [1:0] reg_ptr_t;

endpackage

/* hw/i2c_evt_if.sv */
// bus line events passed from the line monitor to the expander core
`timescale 1ns/10ps
interface i2c_evt_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda;

	modport det (output scl_rise, output scl_fall, output start,
		output stop, output sda);
	modport fsm (input scl_rise, input scl_fall, input start,
		input stop, input sda);
endinterface

/* hw/i2c_line_monitor.sv */
// synchronises scl and sda and reports edges, start and stop
`timescale 1ns/10ps
module i2c_line_monitor (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda,
	i2c_evt_if.det evt
);

	logic [1:0] scl_sync_q;
	logic [1:0] scl_sync_d;
	logic [1:0] sda_sync_q;
	logic [1:0] sda_sync_d;
	logic scl_prev_q;
	logic scl_prev_d;
	logic sda_prev_q;
	logic sda_prev_d;

	always_comb begin
		scl_sync_d = {scl_sync_q[0], i_scl};
		sda_sync_d = {sda_sync_q[0], i_sda};
		scl_prev_d = scl_sync_q[1];
		sda_prev_d = sda_sync_q[1];
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_prev_q <= scl_prev_d;
			sda_prev_q <= sda_prev_d;
		end
	end

	assign evt.scl_rise = scl_sync_q[1] & ~scl_prev_q;
	assign evt.scl_fall = ~scl_sync_q[1] & scl_prev_q;
	assign evt.start = scl_sync_q[1] & scl_prev_q & sda_prev_q
		& ~sda_sync_q[1];
	assign evt.stop = scl_sync_q[1] & scl_prev_q & ~sda_prev_q
		& sda_sync_q[1];
	assign evt.sda = sda_sync_q[1];

endmodule

/* sim/bus_master.sv */
// bus master model: drives scl, pulls sda low open drain
`timescale 1ns/10ps
module bus_master (
	output logic o_scl,
	output logic o_sda_low,
	input wire logic i_sda
);
	localparam realtime Q = 31.25;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic bitx(input logic b, output logic r);
		o_sda_low = ~b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
		#Q;
	endtask
	task automatic start();
		o_sda_low = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b1;
		#Q o_scl = 1'b0;
		#Q;
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_low = 1'b0;
		#Q;
	endtask
	task automatic xfer(input logic [7:0] w, input logic ab,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bitx(w[i], r[i]);
		end
		bitx(ab, a);
	endtask
endmodule

/* sim/gpio_chk.sv */
// assertions on the gpio expander ports
`timescale 1ns/10ps
module gpio_chk #(
	parameter int WIDTH = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda_oe,
	input wire logic [WIDTH-1:0] i_io_lines,
	input wire logic [WIDTH-1:0] o_io_lines,
	input wire logic [WIDTH-1:0] o_io_lines_oe,
	input wire logic [WIDTH-1:0] o_high_side_driver,
	input wire logic [WIDTH-1:0] o_low_side_driver,
	input wire logic [WIDTH-1:0] o_pullup_en,
	input wire logic o_alert_n_oe
);
	logic [3:0] chg_q;
	logic [3:0] scl_q;
	logic [WIDTH-1:0] io_q;
	logic [WIDTH-1:0] pu_q;
	logic sp_q;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			chg_q <= 4'h0;
			scl_q <= 4'h0;
			io_q <= '0;
			pu_q <= '0;
			sp_q <= 1'b0;
		end else begin
			io_q <= i_io_lines;
			pu_q <= o_pullup_en;
			sp_q <= i_scl;
			if (io_q != i_io_lines || pu_q != o_pullup_en)
				chg_q <= 4'h0;
			else if (chg_q != 4'hf)
				chg_q <= chg_q + 4'h1;
			if (i_scl && !sp_q)
				scl_q <= 4'h0;
			else if (scl_q != 4'hf)
				scl_q <= scl_q + 4'h1;
		end
	end
	drv_excl_a: assert property (
		(o_high_side_driver & o_low_side_driver) == '0)
		else $error("both line drivers on");
	drv_high_a: assert property (
		o_high_side_driver == (o_io_lines & o_io_lines_oe))
		else $error("high driver mismatch");
	drv_low_a: assert property (
		o_low_side_driver == (~o_io_lines & o_io_lines_oe))
		else $error("low driver mismatch");
	pullup_dir_a: assert property (
		o_pullup_en == ~o_io_lines_oe)
		else $error("pull-up not tied to direction");
	start_quiet_a: assert property (
		$fell(i_sda) && i_scl |-> (!o_sda_oe) [*8])
		else $error("sda driven right after start");
	sda_edge_a: assert property (
		$changed(o_sda_oe) |-> !i_scl)
		else $error("sda moved while scl high");
	alert_set_a: assert property (
		$rose(o_alert_n_oe) |-> chg_q < 4'hc)
		else $error("alert rose without line change");
	alert_clr_a: assert property (
		$fell(o_alert_n_oe) |-> chg_q < 4'hc || scl_q < 4'hc)
		else $error("alert cleared without cause");
endmodule
bind i2c_gpio_expander_8bit gpio_chk #(.WIDTH(WIDTH)) gpio_chk_i (
	.i_sys_clk, .i_rst_b, .i_scl, .i_sda, .o_sda_oe, .i_io_lines,
	.o_io_lines, .o_io_lines_oe, .o_high_side_driver,
	.o_low_side_driver, .o_pullup_en, .o_alert_n_oe);

/* sim/tb.sv */
// testbench for the i2c gpio expander
`timescale 1ns/10ps
`include "gpio_exp_params.svh"
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] strap = 3'h5;
	logic [7:0] ext = 8'hff;
	logic scl, m_low, sda_oe, al_oe, ak, sda_o, al_o;
	logic [7:0] lo, oe, hi, lw, pu, rb, r1, r2;
	logic [7:0] dflt [4] = '{8'h00, 8'hff, 8'h00, 8'hff};
	wire sda = ~m_low & (~sda_oe | sda_o);
	wire [7:0] pins = (oe & lo) | (~oe & ext);
	int mismatches = 0;
	int num_checks = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	bus_master bus_master_i (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));
	i2c_gpio_expander_8bit i2c_gpio_expander_8bit_i (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda),
		.o_sda_out(sda_o), .o_sda_oe(sda_oe), .i_addr_strap_bit0(strap[0]),
		.i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
		.i_io_lines(pins), .o_io_lines(lo), .o_io_lines_oe(oe),
		.o_high_side_driver(hi), .o_low_side_driver(lw),
		.o_pullup_en(pu), .o_alert_n_out(al_o), .o_alert_n_oe(al_oe));
	task automatic chk(input string nm, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wb(input logic [7:0] v, input logic ea);
		bus_master_i.xfer(v, 1'b1, rb, ak);
		chk("ack", {7'h0, ea}, {7'h0, ak});
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, d1, d2,
		input logic ea);
		// bus edges kept clear of the sampling clock edges
		@(posedge clk);
		#1;
		bus_master_i.start();
		wb({a, 1'b0}, ea);
		wb(p, ea);
		wb(d1, ea);
		wb(d2, ea);
		bus_master_i.stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] p,
		input logic ea);
		// bus edges kept clear of the sampling clock edges
		@(posedge clk);
		#1;
		bus_master_i.start();
		wb({a, 1'b0}, ea);
		wb(p, ea);
		bus_master_i.start();
		wb({a, 1'b1}, ea);
		bus_master_i.xfer(8'hff, 1'b0, r1, ak);
		bus_master_i.xfer(8'hff, 1'b1, r2, ak);
		chk("nack", 8'h01, {7'h0, ak});
		bus_master_i.stop();
	endtask
	task automatic walert(input logic e);
		int n;
		n = 0;
		while (al_oe !== e && n < `ALERT_VALID_CYCLES) begin
			@(negedge clk);
			n++;
		end
		chk("alert", {7'h0, e}, {7'h0, al_oe});
		if (al_oe !== e) begin
			final_report();
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (8) @(negedge clk);
		chk("out", `OUTPUT_RESET, lo);
		chk("oe", 8'h00, oe);
		chk("pullup", 8'hff, pu);
		chk("alert", 8'h00, {7'h0, al_oe});
		chk("sda_out", 8'h00, {7'h0, sda_o});
		chk("alert_out", 8'h00, {7'h0, al_o});
		for (int p = 1; p < 4; p++) begin
			rd(7'h3d, 8'(p), 1'b0);
			chk("dflt", dflt[p], r1);
			chk("rpt", dflt[p], r2);
		end
		wr(7'h3c, 8'h03, 8'h00, 8'h00, 1'b1);
		chk("oe", 8'h00, oe);
		@(posedge clk);
		strap <= 3'h2;
		wr(7'h3a, 8'h01, 8'ha5, 8'h5a, 1'b0);
		wr(7'h3a, 8'h03, 8'h00, 8'hf0, 1'b0);
		repeat (8) @(negedge clk);
		chk("out", 8'h5a, lo);
		chk("oe", 8'h0f, oe);
		chk("high", 8'h0a, hi);
		chk("low", 8'h05, lw);
		chk("pullup", 8'hf0, pu);
		rd(7'h3a, 8'h01, 1'b0);
		chk("outrd", 8'h5a, r2);
		wr(7'h3a, 8'h02, 8'h00, 8'h81, 1'b0);
		@(posedge clk);
		ext <= 8'hc3;
		walert(1'b1);
		rd(7'h3a, 8'h00, 1'b0);
		chk("in", 8'h4b, r1);
		walert(1'b0);
		@(posedge clk);
		ext <= 8'h83;
		walert(1'b1);
		rd(7'h3b, 8'h00, 1'b1);
		chk("alert", 8'h01, {7'h0, al_oe});
		@(posedge clk);
		ext <= 8'hc3;
		walert(1'b0);
		wr(7'h3a, 8'h01, 8'h33, 8'h33, 1'b0);
		repeat (`ALERT_VALID_CYCLES) @(negedge clk);
		chk("alert", 8'h00, {7'h0, al_oe});
		wr(7'h3a, 8'h03, 8'hff, 8'hff, 1'b0);
		walert(1'b1);
		final_report();
	end
endmodule
